/* File: sef_event_flags.sv */
// Event flag, enable and interrupt logic for one serdes channel.
// Assumes the serial engine drives one-cycle event pulses on aclk and
// that line inputs (link pulse, receive enable, spi clock) are async.
`include "sef_params.svh"

module sef_event_flags
    import sef_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic manchester_phase_error,
    input wire logic usb_rx_bit_valid,
    input wire logic usb_rx_bit,
    input wire logic rx_end_of_packet,
    input wire logic rx_sync_detect,
    input wire logic tx_buffer_empty,
    input wire logic tx_shift_done,
    input wire logic tx_buffer_loaded,
    input wire logic rx_buffer_full,
    input wire logic usb_transmitting,
    input wire logic usb_receive_busy,
    input wire logic link_pulse_pin,
    input wire logic energy_pin,
    input wire logic gpsi_receive_enable_input,
    input wire logic spi_clock_pin,
    output logic tx_eop_request,
    output logic irq
);

    // =====================================================================
    // Registers and pin synchronisers
    // =====================================================================
    logic [7:0] serdes_irq_flags_r;
    logic [7:0] serdes_irq_enables_r;
    logic [7:0] mode_r;
    logic [2:0] usb_ones_r;
    logic [1:0] lp_sync_r;
    logic [1:0] en_sync_r;
    logic [1:0] gpsi_receive_enable_input_sync_r;
    logic [1:0] sck_sync_r;
    logic gpsi_receive_enable_input_d_r;
    logic sck_d_r;
    logic carrier_d_r;
    logic [3:0] lp_cnt_r;
    sef_lp_state_t lp_state_r;
    logic tx_pending_r;
    logic [7:0] serdes_irq_flags_nxt;

    sef_mode_t mode;
    logic carrier_sel;
    logic is_10bt;
    logic is_usb;
    logic link_pulse_ok;
    logic carrier_live;
    logic underrun_evt;
    logic eop_evt;
    logic fault_evt;
    logic carrier_evt;
    logic [7:0] set_evt;
    logic [7:0] flags_view;
    logic wr_fire;
    logic [7:0] wr_addr;

    always_comb
    begin
        mode = sef_mode_t'(mode_r[3:0]);
    end
    assign carrier_sel = mode_r[`SEF_BIT_EDGE_SEL];
    assign is_10bt = (mode == SEF_MODE_10BT);
    assign is_usb = (mode == SEF_MODE_USB);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lp_sync_r <= 2'h0;
            en_sync_r <= 2'h0;
            gpsi_receive_enable_input_sync_r <= 2'h0;
            sck_sync_r <= 2'h0;
            gpsi_receive_enable_input_d_r <= 1'b0;
            sck_d_r <= 1'b0;
        end
        else
        begin
            lp_sync_r <= {lp_sync_r[0], link_pulse_pin};
            en_sync_r <= {en_sync_r[0], energy_pin};
            gpsi_receive_enable_input_sync_r <= {gpsi_receive_enable_input_sync_r[0], gpsi_receive_enable_input};
            sck_sync_r <= {sck_sync_r[0], spi_clock_pin};
            gpsi_receive_enable_input_d_r <= gpsi_receive_enable_input_sync_r[1];
            sck_d_r <= sck_sync_r[1];
        end
    end

    // =====================================================================
    // USB unstuffing check
    // =====================================================================
    // Six ones counted; the seventh in a row is the violation.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            usb_ones_r <= 3'h0;
        else if (usb_rx_bit_valid)
        begin
            if (!usb_rx_bit)
                usb_ones_r <= 3'h0;
            else if (usb_ones_r != 3'h6)
                usb_ones_r <= usb_ones_r + 3'h1;
        end
    end

    // =====================================================================
    // Link pulse width measurement
    // =====================================================================
    // Width in whole cycles; a pulse lasting past the maximum is rejected
    // and the counter stops so it cannot wrap into the window again.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lp_state_r <= SEF_LP_IDLE;
            lp_cnt_r <= 4'h0;
        end
        else
        begin
            case (lp_state_r)
                SEF_LP_IDLE:
                begin
                    lp_cnt_r <= 4'h1;
                    if (lp_sync_r[1])
                        lp_state_r <= SEF_LP_HIGH;
                end
                SEF_LP_HIGH:
                begin
                    if (!lp_sync_r[1])
                        lp_state_r <= SEF_LP_IDLE;
                    else if (lp_cnt_r == 4'(`SEF_LINK_MAX_CYC))
                        lp_state_r <= SEF_LP_LONG;
                    else
                        lp_cnt_r <= lp_cnt_r + 4'h1;
                end
                SEF_LP_LONG:
                begin
                    if (!lp_sync_r[1])
                        lp_state_r <= SEF_LP_IDLE;
                end
                default:
                    lp_state_r <= SEF_LP_IDLE;
            endcase
        end
    end

    assign link_pulse_ok = (lp_state_r == SEF_LP_HIGH) && !lp_sync_r[1] &&
        (lp_cnt_r >= 4'(`SEF_LINK_MIN_CYC));

    // =====================================================================
    // Transmit underrun tracking
    // =====================================================================
    // A load marks the buffer as holding fresh data; a shift-out with no
    // fresh data behind it is an underrun.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tx_pending_r <= 1'b0;
        else if (tx_buffer_loaded)
            tx_pending_r <= 1'b1;
        else if (tx_shift_done)
            tx_pending_r <= 1'b0;
    end

    assign underrun_evt = tx_shift_done && !tx_pending_r &&
        !tx_buffer_loaded;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tx_eop_request <= 1'b0;
        else
            tx_eop_request <= underrun_evt && (is_usb || is_10bt);
    end

    // =====================================================================
    // Event sources
    // =====================================================================
    always_comb
    begin
        fault_evt = 1'b0;
        eop_evt = 1'b0;
        carrier_live = 1'b1;
        if (is_10bt)
        begin
            fault_evt = manchester_phase_error;
            eop_evt = rx_end_of_packet;
            carrier_live = !(en_sync_r[1] && lp_sync_r[1]);
        end
        else if (is_usb)
        begin
            fault_evt = usb_rx_bit_valid && usb_rx_bit &&
                (usb_ones_r == 3'h6);
            eop_evt = rx_end_of_packet;
            carrier_live = !usb_receive_busy;
        end
        else if (mode == SEF_MODE_GPSI)
            eop_evt = gpsi_receive_enable_input_d_r && !gpsi_receive_enable_input_sync_r[1];
        else if (mode == SEF_MODE_SPI)
            eop_evt = !sck_d_r && sck_sync_r[1];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            carrier_d_r <= 1'b1;
        else
            carrier_d_r <= carrier_live;
    end

    // Carrier present reads zero; detection is a one-to-zero change, or zero-to-one when the edge select bit is set.
    assign carrier_evt = carrier_sel ? (!carrier_d_r && carrier_live) :
        (carrier_d_r && !carrier_live);

    always_comb
    begin
        set_evt = 8'h00;
        set_evt[`SEF_BIT_RX_FAULT] = fault_evt;
        set_evt[`SEF_BIT_RX_EOP] = eop_evt;
        set_evt[`SEF_BIT_SYNC] = rx_sync_detect && (is_10bt || is_usb);
        set_evt[`SEF_BIT_TX_EMPTY] = tx_buffer_empty;
        set_evt[`SEF_BIT_TX_UNDERRUN] = underrun_evt;
        set_evt[`SEF_BIT_LINK] = is_10bt && link_pulse_ok;
        set_evt[`SEF_BIT_RX_FULL] = rx_buffer_full;
        set_evt[`SEF_BIT_CARRIER] = carrier_evt;
    end

    // =====================================================================
    // AXI4-Lite slave
    // =====================================================================
    // Address and data are taken together, so one write at a time; the
    // response waits for bready before the next write is accepted.
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign wr_addr = {s_axi_awaddr[7:2], 2'b00};
    assign s_axi_bresp = 2'b00;
    assign s_axi_rresp = 2'b00;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_bvalid <= 1'b0;
        else if (wr_fire)
            s_axi_bvalid <= 1'b1;
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            serdes_irq_enables_r <= `SEF_RST_ENABLES;
            mode_r <= `SEF_RST_MODE;
        end
        else if (wr_fire && s_axi_wstrb[0])
        begin
            if (wr_addr == `SEF_OFF_ENABLES)
                serdes_irq_enables_r <= s_axi_wdata[7:0];
            else if (wr_addr == `SEF_OFF_MODE)
                mode_r <= s_axi_wdata[7:0];
        end
    end

    // =====================================================================
    // Sticky flags
    // =====================================================================
    // Zero written to the flag register, or one written to the clear
    // register, drops a bit; a same-cycle event still sets it.
    always_comb
    begin
        serdes_irq_flags_nxt = serdes_irq_flags_r;
        if (wr_fire && s_axi_wstrb[0])
        begin
            if (wr_addr == `SEF_OFF_FLAGS)
                serdes_irq_flags_nxt = serdes_irq_flags_r &
                    s_axi_wdata[7:0];
            else if (wr_addr == `SEF_OFF_CLEAR)
                serdes_irq_flags_nxt = serdes_irq_flags_r &
                    ~s_axi_wdata[7:0];
        end
        serdes_irq_flags_nxt = serdes_irq_flags_nxt | set_evt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            serdes_irq_flags_r <= `SEF_RST_FLAGS;
        else
            serdes_irq_flags_r <= serdes_irq_flags_nxt;
    end

    // In USB mode bit 2 is a live transmit idle view, not a latched flag.
    always_comb
    begin
        flags_view = serdes_irq_flags_r;
        if (is_usb)
            flags_view[`SEF_BIT_LINK] = !usb_transmitting;
        if (is_10bt || is_usb)
            flags_view[`SEF_BIT_CARRIER] = carrier_d_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            case ({s_axi_araddr[7:2], 2'b00})
                `SEF_OFF_FLAGS: s_axi_rdata <= {24'h0, flags_view};
                `SEF_OFF_ENABLES:
                    s_axi_rdata <= {24'h0, serdes_irq_enables_r};
                `SEF_OFF_MODE: s_axi_rdata <= {24'h0, mode_r};
                default: s_axi_rdata <= 32'h0;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // =====================================================================
    // Interrupt
    // =====================================================================
    // Uses the next flag register value, not the read view, so the USB live views do not raise it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |(serdes_irq_flags_nxt & serdes_irq_enables_r);
    end

endmodule : sef_event_flags

/* File: sef_event_flags_assertions.sv */
// Bus and interrupt checks for the serdes event flag block.
// Assumes it is bound onto sef_event_flags and sees only its ports.
module sef_event_flags_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_shift_done,
    input wire logic tx_eop_request,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // =======
    // Steps
    sequence s_wr_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && !s_axi_rvalid;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    // =======
    // Checks
    property p_wr_answer;
        s_wr_take |=> s_axi_bvalid && s_axi_bresp == 2'b00;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write not answered");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write answer dropped");
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_r_hold;
        s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read answer changed");
    property p_r_byte;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_r_byte: assert property (p_r_byte)
        else $error("upper read bits set");
    property p_r_okay;
        s_axi_rvalid |-> s_axi_rresp == 2'b00;
    endproperty
    a_r_okay: assert property (p_r_okay)
        else $error("read answer not okay");
    property p_irq_fall;
        $fell(irq) |-> $past(s_axi_awvalid && s_axi_wvalid)
            || $past(s_axi_awvalid && s_axi_wvalid, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell without a write");
    property p_eop_cause;
        tx_eop_request |-> $past(tx_shift_done) || $past(tx_shift_done, 2);
    endproperty
    a_eop_cause: assert property (p_eop_cause)
        else $error("eop request without shift");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_done: assert property (p_b_done)
        else $error("write answer repeated");
endmodule : sef_event_flags_assertions

bind sef_event_flags sef_event_flags_assertions u_sef_event_flags_assertions (
    .aclk,
    .aresetn,
    .s_axi_awvalid,
    .s_axi_wvalid,
    .s_axi_bresp,
    .s_axi_bvalid,
    .s_axi_bready,
    .s_axi_arvalid,
    .s_axi_rdata,
    .s_axi_rresp,
    .s_axi_rvalid,
    .s_axi_rready,
    .tx_shift_done,
    .tx_eop_request,
    .irq
);

/* File: sef_line_peer.sv */
// Line-side peer: link pulses, energy, gpsi receive enable, spi clock.
// Assumes the bench calls one task at a time, right after a clock edge.
module sef_line_peer (
    input wire logic aclk,
    output logic link_pulse_pin,
    output logic energy_pin,
    output logic gpsi_receive_enable_input,
    output logic spi_clock_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Lines rest low; the spi clock stands still between frames
    initial
    begin
        link_pulse_pin = 1'b0;
        energy_pin = 1'b0;
        gpsi_receive_enable_input = 1'b0;
        spi_clock_pin = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle
    task automatic link(input int n);
        link_pulse_pin <= 1'b1;
        idle(n);
        link_pulse_pin <= 1'b0;
        idle(6);
    endtask : link
    // Long hold, so a held link level never passes as a valid pulse
    task automatic lines(input logic e, input logic l);
        energy_pin <= e;
        link_pulse_pin <= l;
        idle(14);
    endtask : lines
    task automatic spi_edge();
        spi_clock_pin <= 1'b1;
        idle(3);
        spi_clock_pin <= 1'b0;
        idle(6);
    endtask : spi_edge
    task automatic gpsi_frame();
        gpsi_receive_enable_input <= 1'b1;
        idle(4);
        gpsi_receive_enable_input <= 1'b0;
        idle(6);
    endtask : gpsi_frame
endmodule : sef_line_peer

/* File: sef_params.svh */
// Offsets, field positions, reset values and timing counts for the
// serdes event flag block. Assumes a 40 MHz system clock.
`ifndef SEF_PARAMS_SVH
`define SEF_PARAMS_SVH

`define SEF_OFF_FLAGS 8'h00
`define SEF_OFF_ENABLES 8'h04
`define SEF_OFF_MODE 8'h08
`define SEF_OFF_CLEAR 8'h0c

`define SEF_BIT_RX_FAULT 7
`define SEF_BIT_RX_EOP 6
`define SEF_BIT_SYNC 5
`define SEF_BIT_TX_EMPTY 4
`define SEF_BIT_TX_UNDERRUN 3
`define SEF_BIT_LINK 2
`define SEF_BIT_RX_FULL 1
`define SEF_BIT_CARRIER 0

`define SEF_BIT_EDGE_SEL 4

`define SEF_RST_FLAGS 8'h00
`define SEF_RST_ENABLES 8'h00
`define SEF_RST_MODE 8'h00

`define SEF_CLK_PERIOD_NS 25
`define SEF_LINK_MIN_NS 75
`define SEF_LINK_MAX_NS 250
`define SEF_LINK_MIN_CYC ((`SEF_LINK_MIN_NS + `SEF_CLK_PERIOD_NS - 1) / `SEF_CLK_PERIOD_NS)
`define SEF_LINK_MAX_CYC (`SEF_LINK_MAX_NS / `SEF_CLK_PERIOD_NS)

`endif

/* File: sef_pkg.sv */
// Types shared by the serdes event flag block.
// Assumes the params header is compiled alongside.
package sef_pkg;
    typedef enum logic [3:0] {
        SEF_MODE_OFF = 4'b0000,
        SEF_MODE_10BT = 4'b0001,
        SEF_MODE_USB = 4'b0010,
        SEF_MODE_UART = 4'b0011,
        SEF_MODE_SPI = 4'b0101,
        SEF_MODE_GPSI = 4'b0110
    } sef_mode_t;

    typedef enum logic [1:0] {
        SEF_LP_IDLE = 2'b00,
        SEF_LP_HIGH = 2'b01,
        SEF_LP_LONG = 2'b10
    } sef_lp_state_t;
endpackage : sef_pkg

/* File: serdes_event_flags_tb_top.sv */
// Self-checking bench for the serdes event flag block.
// Assumes the line peer and the checker are compiled before it.
`include "sef_params.svh"
`define CHK(nm, ex, gt) \
    begin \
        checks++; \
        if ((gt) !== (ex)) \
        begin \
            err_count++; \
            $display("ERROR %s expected %h seen %h", nm, ex, gt); \
        end \
    end
module serdes_event_flags_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] fl_a = `SEF_OFF_FLAGS;
    localparam logic [7:0] en_a = `SEF_OFF_ENABLES;
    localparam logic [7:0] md_a = `SEF_OFF_MODE;
    localparam logic [7:0] cl_a = `SEF_OFF_CLEAR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] ev = 8'h00;
    logic usb_bit = 1'b0;
    logic usb_tx = 1'b0;
    logic usb_busy = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, link, energy, gpsi;
    logic spi, eop;
    logic [31:0] rdata;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h00016106;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int eop_n = 0;
    int eop_x = 0;
    int wid[4] = '{`SEF_LINK_MIN_CYC - 1, `SEF_LINK_MIN_CYC,
        `SEF_LINK_MAX_CYC, `SEF_LINK_MAX_CYC + 1};
    always #12.5 aclk = ~aclk;
    sef_event_flags u_sef_event_flags (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .manchester_phase_error(ev[7]), .usb_rx_bit_valid(ev[0]),
        .usb_rx_bit(usb_bit), .rx_end_of_packet(ev[6]),
        .rx_sync_detect(ev[5]), .tx_buffer_empty(ev[4]),
        .tx_shift_done(ev[3]), .tx_buffer_loaded(ev[2]),
        .rx_buffer_full(ev[1]), .usb_transmitting(usb_tx),
        .usb_receive_busy(usb_busy), .link_pulse_pin(link),
        .energy_pin(energy), .gpsi_receive_enable_input(gpsi),
        .spi_clock_pin(spi), .tx_eop_request(eop), .irq(irq)
    );
    sef_line_peer u_sef_line_peer (
        .aclk(aclk), .link_pulse_pin(link), .energy_pin(energy),
        .gpsi_receive_enable_input(gpsi), .spi_clock_pin(spi)
    );
    // =======
    // Tasks
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs
    // Event pulse rides with the write, so both land on the same edge
    task automatic axw(input logic [7:0] a, input logic [7:0] d,
        input logic [7:0] e);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        ev <= e;
        do
        begin
            @(posedge aclk);
            if (ev != 8'h00)
                ev <= 8'h00;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && !bready)
                bready <= 1'b1;
        end
        while (!(bvalid && bready));
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && !rready)
                rready <= 1'b1;
        end
        while (!(rvalid && rready));
        rready <= 1'b0;
    endtask : axr
    task automatic fire(input logic [7:0] e);
        ev <= e;
        @(posedge aclk);
        ev <= 8'h00;
        @(posedge aclk);
    endtask : fire
    task automatic mode(input logic [7:0] v);
        axw(md_a, v, 8'h00);
        axw(fl_a, 8'h00, 8'h00);
    endtask : mode
    task automatic usb_run(input int n);
        usb_bit <= 1'b0;
        fire(8'h01);
        usb_bit <= 1'b1;
        repeat (n) fire(8'h01);
        usb_bit <= 1'b0;
        fire(8'h01);
    endtask : usb_run
    task automatic irq_is(input logic x);
        repeat (2) @(posedge aclk);
        `CHK("irq", x, irq)
    endtask : irq_is
    // =======
    // Watchers
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (eop)
            eop_n <= eop_n + 1;
        if (rvalid && rready)
            `CHK("rdata", {24'h000000, exp_q.pop_front()}, rdata)
        if (cyc == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end
    // =======
    // Scenarios
    initial
    begin
        logic [7:0] m;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axr(fl_a, 8'h00);
        axr(en_a, 8'h00);
        axr(8'h10, 8'h00);
        mode(8'h01);
        for (int i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            m = (i == 0) ? 8'hfa : seed[7:0] & 8'hfa;
            fire(m);
            eop_x += int'(m[3]);
            axr(fl_a, m | 8'h01);
            axw(fl_a, 8'hff, 8'h00);
            axr(fl_a, m | 8'h01);
            axw(fl_a, 8'h00, 8'h00);
            axr(fl_a, 8'h01);
        end
        axw(fl_a, 8'h00, 8'h80);
        axr(fl_a, 8'h81);
        axw(cl_a, 8'h80, 8'h00);
        axr(cl_a, 8'h00);
        axr(fl_a, 8'h01);
        axw(en_a, 8'h7e, 8'h80);
        irq_is(1'b0);
        axr(en_a, 8'h7e);
        axw(en_a, 8'h80, 8'h00);
        irq_is(1'b1);
        axw(fl_a, 8'h00, 8'h00);
        irq_is(1'b0);
        axw(en_a, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            u_sef_line_peer.link(wid[i]);
            axr(fl_a, (i == 1 || i == 2) ? 8'h05 : 8'h01);
            axw(fl_a, 8'h00, 8'h00);
        end
        u_sef_line_peer.lines(1'b1, 1'b1);
        axr(fl_a, 8'h00);
        u_sef_line_peer.lines(1'b1, 1'b0);
        axr(fl_a, 8'h01);
        u_sef_line_peer.lines(1'b0, 1'b0);
        mode(8'h02);
        usb_tx <= 1'b1;
        usb_run(6);
        axr(fl_a, 8'h01);
        usb_run(7);
        usb_tx <= 1'b0;
        usb_busy <= 1'b1;
        // Carrier view is registered, so it lags its input by one edge
        @(posedge aclk);
        axr(fl_a, 8'h84);
        axw(en_a, 8'h01, 8'h00);
        irq_is(1'b1);
        axw(fl_a, 8'h00, 8'h00);
        axw(md_a, 8'h12, 8'h00);
        irq_is(1'b0);
        usb_busy <= 1'b0;
        irq_is(1'b1);
        axw(fl_a, 8'h00, 8'h00);
        usb_busy <= 1'b1;
        irq_is(1'b0);
        fire(8'h04);
        fire(8'h08);
        axr(fl_a, 8'h04);
        fire(8'h08);
        eop_x++;
        axr(fl_a, 8'h0c);
        mode(8'h05);
        fire(8'h20);
        axr(fl_a, 8'h00);
        u_sef_line_peer.spi_edge();
        axr(fl_a, 8'h40);
        mode(8'h06);
        u_sef_line_peer.gpsi_frame();
        axr(fl_a, 8'h40);
        `CHK("eop", eop_x, eop_n)
        print_verdict();
    end
endmodule : serdes_event_flags_tb_top
